// *** src/pom_map.svh ***
// register indices, field positions, masks and reset values of the pin mux
`ifndef POM_MAP_SVH
`define POM_MAP_SVH

// register indices; the byte address is four times the index
`define POM_IDX_RXD_SEL 10'h171
`define POM_IDX_STAT_SEL 10'h172
`define POM_IDX_PIN_LEVEL 10'h173

// selector field positions (low bit of each 4-bit field)
`define POM_POS_RXD7 12
`define POM_POS_RXD6 8
`define POM_POS_RXD5 4
`define POM_POS_RXD4 0
`define POM_POS_CRS 8
`define POM_POS_COL 4
`define POM_POS_RXER 0

// writable bits of each selector register
`define POM_RXD_WMASK 16'hFFFF
`define POM_STAT_WMASK_LARGE 16'h0FFF
`define POM_STAT_WMASK_SMALL 16'h00FF

// reset values
`define POM_SEL_RST 16'h0000
`define POM_PIN_RST 1'b0
`define POM_RDATA_RST 32'h0000_0000

`endif

// *** src/pom_pkg.sv ***
// types shared by the pin output mux modules
package pom_pkg;

  // selector codes of every muxed pin
  typedef enum logic [3:0] {
    POM_NORMAL = 4'h0,
    POM_TX_SFD = 4'h1,
    POM_RX_SFD = 4'h2,
    POM_WOL = 4'h3,
    POM_ENERGY = 4'h4,
    POM_RESV5 = 4'h5,
    POM_LED4 = 4'h6,
    POM_PRBS = 4'h7,
    POM_CONST0 = 4'h8,
    POM_CONST1 = 4'h9
  } pom_code_e;

  // link speed as reported by the speed resolution logic
  typedef enum logic [1:0] {
    POM_SPD_10 = 2'h0,
    POM_SPD_100 = 2'h1,
    POM_SPD_1000 = 2'h2
  } pom_speed_e;

  typedef logic [3:0] pom_sel_t;

endpackage

// *** src/pom_src_if.sv ***
// internal indications shared by every pin mux
`timescale 1ns/10ps
interface pom_src_if;
  logic prbs_err;
  logic led4;
  logic energy_ok;
  logic wake_on_lan_flag;
  logic rx_sfd;
  logic tx_sfd;
  modport src (output prbs_err, led4, energy_ok, wake_on_lan_flag, rx_sfd, tx_sfd);
  modport sink (input prbs_err, led4, energy_ok, wake_on_lan_flag, rx_sfd, tx_sfd);
endinterface

// *** src/pom_pin_mux.sv ***
// one registered output multiplexer for a single pin
`timescale 1ns/10ps
`include "pom_map.svh"
module pom_pin_mux (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [3:0] select_in,
  input wire logic normal_in,
  pom_src_if.sink src,
  output logic pin_out
);
  logic pin_d;
  logic pin_q;

  // ------------------------------------------------------------
  // source selection
  // ------------------------------------------------------------
  // reserved codes drive low so a stray write never toggles the pin
  always_comb begin
    case (pom_pkg::pom_code_e'(select_in))
      pom_pkg::POM_NORMAL: pin_d = normal_in;
      pom_pkg::POM_CONST1: pin_d = 1'b1;
      pom_pkg::POM_CONST0: pin_d = 1'b0;
      pom_pkg::POM_PRBS: pin_d = src.prbs_err;
      pom_pkg::POM_LED4: pin_d = src.led4;
      pom_pkg::POM_ENERGY: pin_d = src.energy_ok;
      pom_pkg::POM_WOL: pin_d = src.wake_on_lan_flag;
      pom_pkg::POM_RX_SFD: pin_d = src.rx_sfd;
      pom_pkg::POM_TX_SFD: pin_d = src.tx_sfd;
      default: pin_d = 1'b0;
    endcase
  end

  // registered so the pin is glitch free when the selector changes
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      pin_q <= `POM_PIN_RST;
    end else begin
      pin_q <= pin_d;
    end
  end

  assign pin_out = pin_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);

  a_code_normal: assert property (
    select_in == pom_pkg::POM_NORMAL |=> pin_out == $past(normal_in))
    else $error("pin does not follow its normal signal");
  a_code_const: assert property (
    (select_in == pom_pkg::POM_CONST1 |=> pin_out) and
    (select_in == pom_pkg::POM_CONST0 |=> !pin_out))
    else $error("constant codes do not drive one then zero");
  a_code_prbs: assert property (
    select_in == pom_pkg::POM_PRBS |=> pin_out == $past(src.prbs_err))
    else $error("prbs indication not routed");
  a_code_led: assert property (
    select_in == pom_pkg::POM_LED4 |=> pin_out == $past(src.led4))
    else $error("led indication not routed");
  a_code_energy: assert property (
    select_in == pom_pkg::POM_ENERGY |=> pin_out == $past(src.energy_ok))
    else $error("energy indication not routed");
  a_code_wol: assert property (
    select_in == pom_pkg::POM_WOL |=> pin_out == $past(src.wake_on_lan_flag))
    else $error("wake indication not routed");
  a_code_sfd: assert property (
    (select_in == pom_pkg::POM_RX_SFD && src.rx_sfd) ||
    (select_in == pom_pkg::POM_TX_SFD && src.tx_sfd) |=> pin_out)
    else $error("frame delimiter pulse not routed");
  a_code_resv: assert property (
    select_in > pom_pkg::POM_CONST1 || select_in == pom_pkg::POM_RESV5
    |=> !pin_out)
    else $error("reserved code does not hold the pin low");
endmodule

// *** src/pom_top.sv ***
// apb register file and pin muxes for the mac side data and status pins
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/10ps
`include "pom_map.svh"
// What this block does
// - code 0000 keeps the pin's normal signal
// - code 1001 drives one, 1000 drives zero
// - code 0111 routes prbs error or sync loss
// - code 0110 routes fourth led; 0101 reserved
// - code 0100 energy detect, only 100/1000
// - code 0011 routes wake-on-lan flag
// - codes 0010/0001 route rx/tx sfd pulse
// - data pin select register only on large
// - rxd7..4 selectors in 15:12 down to 3:0
// - large: crs 11:8, col 7:4, rxer 3:0
// - small: gpio1 7:4, gpio0 3:0, rest reserved
// - small default puts col and rxer on gpio
module pom_top #(
  parameter bit LARGE_PKG = 1'b1,
  parameter int ADDR_W = 12
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic apb_psel_in,
  input wire logic apb_penable_in,
  input wire logic apb_pwrite_in,
  input wire logic [ADDR_W-1:0] apb_paddr_in,
  input wire logic [31:0] apb_pwdata_in,
  output logic [31:0] apb_prdata_out,
  output logic apb_pready_out,
  output logic apb_pslverr_out,
  input wire logic [1:0] speed_in,
  input wire logic [3:0] rxd_hi_in,
  input wire logic crs_in,
  input wire logic col_in,
  input wire logic rx_er_in,
  input wire logic prbs_err_in,
  input wire logic fourth_led_signal_in,
  input wire logic energy_detect_in,
  input wire logic wake_on_lan_flag_in,
  input wire logic rx_sfd_in,
  input wire logic tx_sfd_in,
  output logic [3:0] rxd_hi_out,
  output logic crs_out,
  output logic col_out,
  output logic rx_er_out
);
  localparam int NPINS = 7;

  // ------------------------------------------------------------
  // parameter checks
  // ------------------------------------------------------------
  // the word index needs ten address bits above the byte lanes
  if (ADDR_W < 12) begin : g_bad_addr
    $error("ADDR_W must be at least 12");
  end

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  // true only for the word-aligned byte address of a register index, upper bits zero
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [9:0] idx);
    reg_hit = (addr[11:2] == idx) && (addr[1:0] == 2'h0) &&
              ((addr >> 12) == '0);
  endfunction

  // pulls one 4-bit selector out of a register image
  function automatic pom_pkg::pom_sel_t sel_field(input logic [15:0] r,
                                                  input int pos);
    sel_field = r[pos +: 4];
  endfunction

  // ------------------------------------------------------------
  // apb access decode
  // ------------------------------------------------------------
  logic setup_ph;
  logic access_ph;
  logic wr_en;
  logic hit_rxd;
  logic hit_stat;
  logic hit_lvl;
  logic mapped;
  logic [15:0] stat_wmask;

  assign setup_ph = apb_psel_in && !apb_penable_in;
  assign access_ph = apb_psel_in && apb_penable_in;
  assign wr_en = access_ph && apb_pwrite_in;
  assign hit_rxd = reg_hit(apb_paddr_in, `POM_IDX_RXD_SEL);
  assign hit_stat = reg_hit(apb_paddr_in, `POM_IDX_STAT_SEL);
  assign hit_lvl = reg_hit(apb_paddr_in, `POM_IDX_PIN_LEVEL);
  // the small package has no data pin selector register
  assign mapped = (hit_rxd && LARGE_PKG) || hit_stat || hit_lvl;
  assign stat_wmask = LARGE_PKG ? `POM_STAT_WMASK_LARGE
                                : `POM_STAT_WMASK_SMALL;
  // zero wait states: every access phase completes at once
  assign apb_pready_out = 1'b1;

  // ------------------------------------------------------------
  // selector registers
  // ------------------------------------------------------------
  logic [15:0] rxd_sel_q;
  logic [15:0] rxd_sel_d;
  logic [15:0] stat_sel_q;
  logic [15:0] stat_sel_d;

  // reserved bits are masked at the write, so they always read zero
  always_comb begin
    rxd_sel_d = rxd_sel_q;
    stat_sel_d = stat_sel_q;
    if (wr_en && hit_rxd && LARGE_PKG) begin
      rxd_sel_d = apb_pwdata_in[15:0] & `POM_RXD_WMASK;
    end
    if (wr_en && hit_stat) begin
      stat_sel_d = apb_pwdata_in[15:0] & stat_wmask;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rxd_sel_q <= `POM_SEL_RST;
      stat_sel_q <= `POM_SEL_RST;
    end else begin
      rxd_sel_q <= rxd_sel_d;
      stat_sel_q <= stat_sel_d;
    end
  end

  // ------------------------------------------------------------
  // read data and error response
  // ------------------------------------------------------------
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic slverr_d;
  logic slverr_q;
  logic [NPINS-1:0] pin_lvl;

  // captured in the setup phase so data is stable through access
  always_comb begin
    rdata_d = rdata_q;
    slverr_d = slverr_q;
    if (setup_ph) begin
      rdata_d = `POM_RDATA_RST;
      slverr_d = !mapped;
      if (hit_rxd && LARGE_PKG) begin
        rdata_d[15:0] = rxd_sel_q;
      end else if (hit_stat) begin
        rdata_d[15:0] = stat_sel_q;
      end else if (hit_lvl) begin
        rdata_d[NPINS-1:0] = pin_lvl;
      end
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_q <= `POM_RDATA_RST;
      slverr_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      slverr_q <= slverr_d;
    end
  end

  assign apb_prdata_out = rdata_q;
  // error shows only while the access phase is on the bus
  assign apb_pslverr_out = access_ph && slverr_q;

  // ------------------------------------------------------------
  // internal indications and the pin muxes
  // ------------------------------------------------------------
  pom_src_if src_bus ();

  // energy detect means nothing at 10 Mb/s, so it reads low there
  assign src_bus.energy_ok = energy_detect_in &&
    (pom_pkg::pom_speed_e'(speed_in) != pom_pkg::POM_SPD_10);
  assign src_bus.prbs_err = prbs_err_in;
  assign src_bus.led4 = fourth_led_signal_in;
  assign src_bus.wake_on_lan_flag = wake_on_lan_flag_in;
  assign src_bus.rx_sfd = rx_sfd_in;
  assign src_bus.tx_sfd = tx_sfd_in;

  logic [NPINS-1:0][3:0] pin_sel;
  logic [NPINS-1:0] pin_norm;

  // pin order: rx_er, col, crs, rxd4..rxd7; on the small package
  // rx_er and col are the two general purpose pins
  always_comb begin
    pin_sel[0] = sel_field(stat_sel_q, `POM_POS_RXER);
    pin_sel[1] = sel_field(stat_sel_q, `POM_POS_COL);
    pin_sel[2] = sel_field(stat_sel_q, `POM_POS_CRS);
    pin_sel[3] = sel_field(rxd_sel_q, `POM_POS_RXD4);
    pin_sel[4] = sel_field(rxd_sel_q, `POM_POS_RXD5);
    pin_sel[5] = sel_field(rxd_sel_q, `POM_POS_RXD6);
    pin_sel[6] = sel_field(rxd_sel_q, `POM_POS_RXD7);
  end

  // code zero on the small package gives col and rx_er as well
  assign pin_norm = {rxd_hi_in, crs_in, col_in, rx_er_in};

  for (genvar i = 0; i < NPINS; i++) begin : g_pin
    pom_pin_mux u_mux (
      .clock_in (clock_in),
      .rst_in (rst_in),
      .select_in (pin_sel[i]),
      .normal_in (pin_norm[i]),
      .src (src_bus.sink),
      .pin_out (pin_lvl[i])
    );
  end

  assign rx_er_out = pin_lvl[0];
  assign col_out = pin_lvl[1];
  assign crs_out = pin_lvl[2];
  assign rxd_hi_out = pin_lvl[6:3];

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);

  sequence s_wr_stat;
    wr_en && hit_stat;
  endsequence

  sequence s_set_rxer_one;
    s_wr_stat ##0 apb_pwdata_in[3:0] == pom_pkg::POM_CONST1;
  endsequence

  a_small_absent: assert property (
    !LARGE_PKG && access_ph && hit_rxd
    |-> apb_pslverr_out && apb_prdata_out == '0)
    else $error("small package answers the data pin register");
  a_rxd_fields: assert property (
    LARGE_PKG && wr_en && hit_rxd
    |=> pin_sel[6] == $past(apb_pwdata_in[15:12]) &&
        pin_sel[3] == $past(apb_pwdata_in[3:0]))
    else $error("data pin selector fields misplaced");
  a_stat_resv: assert property (
    access_ph && hit_stat && !apb_pwrite_in
    |-> (apb_prdata_out & ~{16'h0000, stat_wmask}) == '0)
    else $error("reserved selector bits read nonzero");
  a_stat_write: assert property (
    s_wr_stat |=> stat_sel_q == $past(apb_pwdata_in[15:0] & stat_wmask))
    else $error("status pin selector write lost");
  a_small_default: assert property (
    !LARGE_PKG && stat_sel_q[7:0] == '0
    |=> col_out == $past(col_in) && rx_er_out == $past(rx_er_in))
    else $error("general purpose pins lost their defaults");
  a_select_latency: assert property (
    s_set_rxer_one |-> ##2 rx_er_out)
    else $error("selector change not on pin two edges later");
  a_energy_gate: assert property (
    pom_pkg::pom_speed_e'(speed_in) == pom_pkg::POM_SPD_10
    |-> !src_bus.energy_ok)
    else $error("energy detect passed at 10 Mb/s");
  a_read_back: assert property (
    LARGE_PKG && wr_en && hit_rxd ##2 setup_ph && hit_rxd
    |=> apb_prdata_out[15:0] == $past(apb_pwdata_in[15:0], 3))
    else $error("data pin selector read back wrong");
endmodule

// *** sim/pom_mac_model.sv ***
// behavioural mac side that samples the muxed pins
`timescale 1ns/10ps
module pom_mac_model (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [8:0] pins_in,
  output logic [8:0] seen_out
);
  // the mac registers the pins on its own edge, so it sees them one late
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      seen_out <= 9'h000;
    end else begin
      seen_out <= pins_in;
    end
  end
endmodule

// *** sim/testbench.sv ***
// self-checking bench for the pin output mux, both package variants
`timescale 1ns/10ps
`include "pom_map.svh"
module testbench;
  // ------------------------------------------------------------
  // stimulus, design instances and mac model
  // ------------------------------------------------------------
  localparam logic [11:0] ADDR_RXD = {`POM_IDX_RXD_SEL, 2'b00};
  localparam logic [11:0] ADDR_STAT = {`POM_IDX_STAT_SEL, 2'b00};
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic psel = 1'b0;
  logic psel_small = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [1:0] speed = 2'h2;
  logic [3:0] rxd_hi = 4'hA;
  logic [2:0] stat = 3'h5; // crs, col, rx_er normal levels
  logic [7:0] ind = 8'h00; // one indication per selector code
  logic [31:0] prdata, prdata_small;
  logic ready, ready_small, err, err_small;
  logic [3:0] rxd_pins;
  logic crs_pin, col_pin, rxer_pin, col_small, rxer_small;
  logic [8:0] seen;
  int num_errors = 0;
  int checks_done = 0;

  always #10 clock_in = ~clock_in;

  // both instances share the bus; only the select line differs
  pom_top #(.LARGE_PKG(1'b1), .ADDR_W(12)) pom_top_i (
    .clock_in(clock_in), .rst_in(rst_in), .apb_psel_in(psel),
    .apb_penable_in(penable), .apb_pwrite_in(pwrite),
    .apb_paddr_in(paddr), .apb_pwdata_in(pwdata), .apb_prdata_out(prdata),
    .apb_pready_out(ready), .apb_pslverr_out(err), .speed_in(speed),
    .rxd_hi_in(rxd_hi), .crs_in(stat[2]), .col_in(stat[1]),
    .rx_er_in(stat[0]), .prbs_err_in(ind[7]), .fourth_led_signal_in(ind[6]),
    .energy_detect_in(ind[4]), .wake_on_lan_flag_in(ind[3]),
    .rx_sfd_in(ind[2]), .tx_sfd_in(ind[1]), .rxd_hi_out(rxd_pins),
    .crs_out(crs_pin), .col_out(col_pin), .rx_er_out(rxer_pin));
  pom_top #(.LARGE_PKG(1'b0), .ADDR_W(12)) pom_top_small_i (
    .clock_in(clock_in), .rst_in(rst_in), .apb_psel_in(psel_small),
    .apb_penable_in(penable), .apb_pwrite_in(pwrite),
    .apb_paddr_in(paddr), .apb_pwdata_in(pwdata),
    .apb_prdata_out(prdata_small), .apb_pready_out(ready_small),
    .apb_pslverr_out(err_small), .speed_in(speed), .rxd_hi_in(rxd_hi),
    .crs_in(stat[2]), .col_in(stat[1]), .rx_er_in(stat[0]),
    .prbs_err_in(ind[7]), .fourth_led_signal_in(ind[6]),
    .energy_detect_in(ind[4]), .wake_on_lan_flag_in(ind[3]),
    .rx_sfd_in(ind[2]), .tx_sfd_in(ind[1]), .rxd_hi_out(),
    .crs_out(), .col_out(col_small), .rx_er_out(rxer_small));
  pom_mac_model pom_mac_model_i (.clock_in(clock_in), .rst_in(rst_in),
    .pins_in({rxd_pins, crs_pin, col_pin, rxer_pin, col_small, rxer_small}),
    .seen_out(seen));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer; the wait has no fixed length, the watchdog bounds it
  task automatic apb(input bit sm, input bit wr, input logic [11:0] a,
      input logic [31:0] wd, output logic [31:0] rd, output logic er);
    @(posedge clock_in);
    psel <= !sm;
    psel_small <= sm;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock_in);
    penable <= 1'b1;
    do @(posedge clock_in); while ((sm ? ready_small : ready) !== 1'b1);
    rd = sm ? prdata_small : prdata;
    er = sm ? err_small : err;
    psel <= 1'b0;
    psel_small <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input bit sm, input logic [11:0] a,
      input logic [31:0] d, input logic eerr);
    logic [31:0] rd;
    logic er;
    apb(sm, 1'b1, a, d, rd, er);
    check({31'h0, er}, {31'h0, eerr});
  endtask
  task automatic rdchk(input bit sm, input logic [11:0] a,
      input logic [31:0] exp, input logic eerr);
    logic [31:0] rd;
    logic er;
    apb(sm, 1'b0, a, 32'h0000_0000, rd, er);
    check(rd, exp);
    check({31'h0, er}, {31'h0, eerr});
  endtask
  // pin register plus the mac's own stage, so three edges are enough
  task automatic pins(input logic [8:0] exp);
    repeat (3) @(posedge clock_in);
    check({23'h0, seen}, {23'h0, exp});
  endtask
  task automatic setall(input int c);
    wr(0, ADDR_RXD, c * 32'h1111, 1'b0);
    wr(0, ADDR_STAT, c * 32'h0111, 1'b0);
    wr(1, ADDR_STAT, c * 32'h0011, 1'b0);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    rdchk(0, ADDR_RXD, 32'h0000_0000, 1'b0);
    rdchk(1, ADDR_STAT, 32'h0000_0000, 1'b0);
    pins({rxd_hi, stat, stat[1:0]});
    rxd_hi <= 4'h5;
    stat <= 3'h2;
    pins({4'h5, 3'h2, 2'h2});
    $display("test reset done");
  endtask
  // normal levels are the inverse of the constants, so a swap shows
  task automatic t_fields();
    wr(0, ADDR_RXD, 32'hFFFF_9889, 1'b0);
    rdchk(0, ADDR_RXD, 32'h0000_9889, 1'b0);
    wr(0, ADDR_STAT, 32'hFFFF_F898, 1'b0);
    wr(1, ADDR_STAT, 32'hFFFF_FF98, 1'b0);
    rdchk(0, ADDR_RXD, 32'h0000_9889, 1'b0);
    rdchk(0, ADDR_STAT, 32'h0000_0898, 1'b0);
    rdchk(1, ADDR_STAT, 32'h0000_0098, 1'b0);
    rxd_hi <= 4'h6;
    stat <= 3'h5;
    pins({4'h9, 3'h2, 2'h2});
    // a one on rx_er checks the two-edge path from write to pin
    wr(0, ADDR_STAT, 32'h0000_0899, 1'b0);
    pins({4'h9, 3'h3, 2'h2});
    rdchk(1, ADDR_RXD, 32'h0000_0000, 1'b1);
    wr(1, ADDR_RXD, 32'h0000_1111, 1'b1);
    rdchk(0, 12'h5D0, 32'h0000_0000, 1'b1);
    $display("test fields done");
  endtask
  // codes 0001 to 0111: each indication alone high, then alone low among the others
  task automatic t_codes();
    for (int c = 1; c < 8; c++) begin
      setall(c); // codes stay below 1010
      ind <= 8'h01 << c;
      pins((c == 5) ? 9'h000 : 9'h1FF);
      ind <= ~(8'h01 << c);
      pins(9'h000);
    end
    setall(4);
    ind <= 8'hFF;
    speed <= 2'h0;
    pins(9'h000);
    speed <= 2'h1;
    pins(9'h1FF);
    $display("test codes done");
  endtask
  task automatic t_rerun();
    @(posedge clock_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    rst_in <= 1'b0;
    rdchk(0, ADDR_STAT, 32'h0000_0000, 1'b0);
    pins({rxd_hi, stat, stat[1:0]});
    $display("test second reset done");
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clock_in);
    rst_in <= 1'b0;
    t_reset();
    t_fields();
    t_codes();
    t_rerun();
    give_verdict();
  end
  // watchdog: the tests need well under 1000 cycles
  initial begin
    repeat (20000) @(posedge clock_in);
    num_errors++;
    give_verdict();
  end
endmodule
